// *** rtl/peripheral_irq_flag_bank.sv ***
// Peripheral request flag bank with enables, reached over APB
`timescale 1ns/100ps
`include "irq_flag_defs.svh"
module peripheral_irq_flag_bank #(
	parameter int PIN_CHANGE_W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_ADDR_W-1:0] paddr,
	input wire logic [`APB_DATA_W-1:0] pwdata,
	output logic [`APB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer events, one-cycle pulses
	input wire logic timer0_overflow,
	input wire logic timer1_event,
	input wire logic timer2_event,
	input wire logic timer1_gate_inactive,
	// Capture/compare events, one-cycle pulses
	input wire logic capcmp1_event,
	input wire logic capcmp2_event,
	// Serial and converter events, one-cycle pulses
	input wire logic sync_serial_event,
	input wire logic bus_collision_event,
	input wire logic adc_done_event,
	input wire logic flash_done_event,
	// Live levels from neighbouring blocks
	input wire logic [PIN_CHANGE_W-1:0] per_pin_change_flags,
	input wire logic serial_rx_not_empty,
	input wire logic serial_tx_buffer_empty,
	// External request pin, asynchronous
	input wire logic ext_pin,
	// Request to the processor
	output logic irq_request
);

	// ==========================================================
	// State
	// ==========================================================
	irq_flag_pkg::bank_state_t s_q;
	irq_flag_pkg::bank_state_t s_d;

	logic ext_pin_flag_event;
	logic want_vector;
	logic [7:0] view_0;
	logic [7:0] view_1;
	logic [7:0] view_2;
	logic [7:0] events_0;
	logic [7:0] events_1;
	logic [7:0] events_2;
	logic [`REG_IDX_W-1:0] reg_idx;
	logic access_phase;
	logic commit;
	logic addr_hit;
	logic write_hit;

	// ==========================================================
	// Write strobes
	// ==========================================================
	logic wr_control;
	logic wr_flags_0;
	logic wr_flags_1;
	logic wr_flags_2;
	logic wr_enables_0;
	logic wr_enables_1;
	logic wr_enables_2;

	// ==========================================================
	// Address decoding
	// ==========================================================
	function automatic logic [`REG_IDX_W-1:0] word_index(
		input logic [`APB_ADDR_W-1:0] addr
	);
		word_index = addr[`APB_ADDR_W-1:`APB_WORD_LSB];
	endfunction

	function automatic logic index_known(
		input logic [`REG_IDX_W-1:0] idx
	);
		case (idx)
			`IDX_IRQ_CONTROL,
			`IDX_REQUEST_FLAGS_0,
			`IDX_REQUEST_FLAGS_1,
			`IDX_REQUEST_FLAGS_2,
			`IDX_SOURCE_ENABLES_0,
			`IDX_SOURCE_ENABLES_1,
			`IDX_SOURCE_ENABLES_2: index_known = 1'b1;
			default: index_known = 1'b0;
		endcase
	endfunction

	function automatic logic is_target(
		input logic hit,
		input logic [`REG_IDX_W-1:0] idx,
		input logic [`REG_IDX_W-1:0] target
	);
		is_target = hit && (idx == target);
	endfunction

	// ==========================================================
	// Neighbour blocks
	// ==========================================================
	ext_pin_edge u_ext_pin_edge (
		.pclk(pclk),
		.presetn(presetn),
		.ext_pin(ext_pin),
		.edge_rising(s_q.ext_edge_rising),
		.edge_pulse(ext_pin_flag_event)
	);

	irq_source_merge u_irq_source_merge (
		.flags_0(view_0),
		.flags_1(view_1),
		.flags_2(view_2),
		.enables_0(s_q.enables_0),
		.enables_1(s_q.enables_1),
		.enables_2(s_q.enables_2),
		.global_irq_enable(s_q.global_irq_enable),
		.peripheral_group_enable(s_q.peripheral_group_enable),
		.want_vector(want_vector)
	);

	// ==========================================================
	// Flag views: stored sticky bits plus live levels
	// ==========================================================
	always_comb
	begin
		view_0 = s_q.flags_0;
		view_0[`BIT_PIN_CHANGE_SUMMARY] = |per_pin_change_flags;
		view_1 = s_q.flags_1;
		view_1[`BIT_SERIAL_RX_READY] = serial_rx_not_empty;
		view_1[`BIT_SERIAL_TX_EMPTY] = serial_tx_buffer_empty;
		view_2 = s_q.flags_2;
	end

	// ==========================================================
	// Hardware set events, taken with no enable gating
	// ==========================================================
	always_comb
	begin
		events_0 = `RESET_BYTE;
		events_0[`BIT_TIMER0_OVERFLOW] = timer0_overflow;
		events_0[`BIT_EXT_PIN] = ext_pin_flag_event;
		events_1 = `RESET_BYTE;
		events_1[`BIT_CAPCMP1] = capcmp1_event;
		events_1[`BIT_TIMER2] = timer2_event;
		events_1[`BIT_TIMER1] = timer1_event;
		events_1[`BIT_BUS_COLLISION] = bus_collision_event;
		events_1[`BIT_SYNC_SERIAL] = sync_serial_event;
		events_1[`BIT_ADC_DONE] = adc_done_event;
		events_2 = `RESET_BYTE;
		events_2[`BIT_CAPCMP2] = capcmp2_event;
		events_2[`BIT_FLASH_DONE] = flash_done_event;
		events_2[`BIT_TIMER1_GATE] = timer1_gate_inactive;
	end

	// ==========================================================
	// Bus decode
	// ==========================================================
	always_comb
	begin
		reg_idx = word_index(paddr);
		access_phase = psel & penable;
		commit = access_phase & s_q.pready;
		addr_hit = index_known(reg_idx)
			&& (paddr[`APB_WORD_LSB-1:0] == `APB_ALIGN_OK);
		write_hit = commit & pwrite & addr_hit;
	end

	// ==========================================================
	// One strobe per writable register
	// ==========================================================
	always_comb
	begin
		wr_control = is_target(write_hit, reg_idx, `IDX_IRQ_CONTROL);
		wr_flags_0 = is_target(write_hit, reg_idx, `IDX_REQUEST_FLAGS_0);
		wr_flags_1 = is_target(write_hit, reg_idx, `IDX_REQUEST_FLAGS_1);
		wr_flags_2 = is_target(write_hit, reg_idx, `IDX_REQUEST_FLAGS_2);
		wr_enables_0 = is_target(write_hit, reg_idx, `IDX_SOURCE_ENABLES_0);
		wr_enables_1 = is_target(write_hit, reg_idx, `IDX_SOURCE_ENABLES_1);
		wr_enables_2 = is_target(write_hit, reg_idx, `IDX_SOURCE_ENABLES_2);
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		s_d = s_q;

		// Answer one cycle into the access phase, release after
		case (s_q.phase)
			irq_flag_pkg::PH_IDLE:
			begin
				if (access_phase)
				begin
					s_d.phase = irq_flag_pkg::PH_ANSWER;
					s_d.pready = 1'b1;
					s_d.pslverr = ~addr_hit;
					s_d.prdata = `RESET_WORD;
					if (addr_hit && !pwrite)
					begin
						case (reg_idx)
							`IDX_IRQ_CONTROL:
							begin
								s_d.prdata[`BIT_GLOBAL_IRQ_ENABLE] =
									s_q.global_irq_enable;
								s_d.prdata[`BIT_PERIPHERAL_GROUP_ENABLE] =
									s_q.peripheral_group_enable;
								s_d.prdata[`BIT_EXT_EDGE_RISING] =
									s_q.ext_edge_rising;
							end
							`IDX_REQUEST_FLAGS_0:
								s_d.prdata = {`BYTE_PAD, view_0};
							`IDX_REQUEST_FLAGS_1:
								s_d.prdata = {`BYTE_PAD, view_1};
							`IDX_REQUEST_FLAGS_2:
								s_d.prdata = {`BYTE_PAD, view_2};
							`IDX_SOURCE_ENABLES_0:
								s_d.prdata = {`BYTE_PAD, s_q.enables_0};
							`IDX_SOURCE_ENABLES_1:
								s_d.prdata = {`BYTE_PAD, s_q.enables_1};
							`IDX_SOURCE_ENABLES_2:
								s_d.prdata = {`BYTE_PAD, s_q.enables_2};
							default:
								s_d.prdata = `RESET_WORD;
						endcase
					end
				end
			end
			irq_flag_pkg::PH_ANSWER:
			begin
				s_d.phase = irq_flag_pkg::PH_IDLE;
				s_d.pready = 1'b0;
				s_d.pslverr = 1'b0;
				s_d.prdata = `RESET_WORD;
			end
			default:
			begin
				s_d.phase = irq_flag_pkg::PH_IDLE;
				s_d.pready = 1'b0;
				s_d.pslverr = 1'b0;
				s_d.prdata = `RESET_WORD;
			end
		endcase

		// Control: global enable, group enable, pin edge choice
		if (wr_control)
		begin
			s_d.global_irq_enable = pwdata[`BIT_GLOBAL_IRQ_ENABLE];
			s_d.peripheral_group_enable =
				pwdata[`BIT_PERIPHERAL_GROUP_ENABLE];
			s_d.ext_edge_rising = pwdata[`BIT_EXT_EDGE_RISING];
		end

		// Enables; unimplemented bits stay zero
		if (wr_enables_0)
		begin
			s_d.enables_0 = pwdata[`REG_BYTE_W-1:0] & `MASK_ENABLES_0;
		end
		if (wr_enables_1)
		begin
			s_d.enables_1 = pwdata[`REG_BYTE_W-1:0] & `MASK_ENABLES_1;
		end
		if (wr_enables_2)
		begin
			s_d.enables_2 = pwdata[`REG_BYTE_W-1:0] & `MASK_ENABLES_2;
		end

		// Sticky flags: write stores, then an event ORs in on top
		if (wr_flags_0)
		begin
			s_d.flags_0 = pwdata[`REG_BYTE_W-1:0];
		end
		if (wr_flags_1)
		begin
			s_d.flags_1 = pwdata[`REG_BYTE_W-1:0];
		end
		if (wr_flags_2)
		begin
			s_d.flags_2 = pwdata[`REG_BYTE_W-1:0];
		end
		s_d.flags_0 = (s_d.flags_0 | events_0) & `MASK_STICKY_0;
		s_d.flags_1 = (s_d.flags_1 | events_1) & `MASK_STICKY_1;
		s_d.flags_2 = (s_d.flags_2 | events_2) & `MASK_STICKY_2;

		// Enabling with a flag already set requests one cycle after the enable is stored
		s_d.irq_request = want_vector;
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.phase <= irq_flag_pkg::PH_IDLE;
			s_q.ext_edge_rising <= `RESET_EXT_EDGE_RISING;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	always_comb
	begin
		prdata = s_q.prdata;
		pready = s_q.pready;
		pslverr = s_q.pslverr;
		irq_request = s_q.irq_request;
	end

endmodule // peripheral_irq_flag_bank

// *** rtl/irq_flag_defs.svh ***
// Register indices, bit positions, masks and reset values of the flag bank
`ifndef IRQ_FLAG_DEFS_SVH
`define IRQ_FLAG_DEFS_SVH

// ==========================================================
// Bus geometry
// ==========================================================
`define APB_ADDR_W 16
`define REG_IDX_W 14
`define REG_BYTE_W 8
`define APB_DATA_W 32
`define APB_WORD_LSB 2
`define APB_ALIGN_OK 2'h0

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define IDX_IRQ_CONTROL 14'h000B
`define IDX_REQUEST_FLAGS_0 14'h070C
`define IDX_REQUEST_FLAGS_1 14'h070D
`define IDX_REQUEST_FLAGS_2 14'h070E
`define IDX_SOURCE_ENABLES_0 14'h0716
`define IDX_SOURCE_ENABLES_1 14'h0717
`define IDX_SOURCE_ENABLES_2 14'h0718

// ==========================================================
// Bit positions
// ==========================================================
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_GROUP_ENABLE 6
`define BIT_EXT_EDGE_RISING 0
`define BIT_TIMER0_OVERFLOW 5
`define BIT_PIN_CHANGE_SUMMARY 4
`define BIT_EXT_PIN 0
`define BIT_CAPCMP1 7
`define BIT_TIMER2 6
`define BIT_TIMER1 5
`define BIT_SERIAL_RX_READY 4
`define BIT_SERIAL_TX_EMPTY 3
`define BIT_BUS_COLLISION 2
`define BIT_SYNC_SERIAL 1
`define BIT_ADC_DONE 0
`define BIT_CAPCMP2 7
`define BIT_FLASH_DONE 6
`define BIT_TIMER1_GATE 5

// ==========================================================
// Masks of implemented bits
// ==========================================================
`define MASK_CONTROL 8'hC1
`define MASK_STICKY_0 8'h21
`define MASK_STICKY_1 8'hE7
`define MASK_STICKY_2 8'hE0
`define MASK_ENABLES_0 8'h31
`define MASK_ENABLES_1 8'hFF
`define MASK_ENABLES_2 8'hE0

// ==========================================================
// Reset values
// ==========================================================
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h0000_0000
`define RESET_EXT_EDGE_RISING 1'b1
`define BYTE_PAD 24'h0000_00

`endif

// *** rtl/irq_flag_pkg.sv ***
// Types shared by the flag bank modules
package irq_flag_pkg;

	// ==========================================================
	// Bus answer sequencing
	// ==========================================================
	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_ANSWER = 2'b10
	} apb_phase_t;

	// ==========================================================
	// State of the flag bank
	// ==========================================================
	typedef struct packed {
		apb_phase_t phase;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] flags_0;
		logic [7:0] flags_1;
		logic [7:0] flags_2;
		logic [7:0] enables_0;
		logic [7:0] enables_1;
		logic [7:0] enables_2;
		logic global_irq_enable;
		logic peripheral_group_enable;
		logic ext_edge_rising;
		logic irq_request;
	} bank_state_t;

	// ==========================================================
	// State of the pin edge detector
	// ==========================================================
	typedef struct packed {
		logic meta;
		logic stable;
		logic last;
		logic [2:0] filled;
	} edge_state_t;

endpackage

// *** rtl/ext_pin_edge.sv ***
// Synchroniser and selectable edge detector for the external request pin
`timescale 1ns/100ps
module ext_pin_edge (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and edge choice
	input wire logic ext_pin,
	input wire logic edge_rising,
	// One-cycle pulse on a valid edge
	output logic edge_pulse
);

	irq_flag_pkg::edge_state_t s_q;
	irq_flag_pkg::edge_state_t s_d;

	// ==========================================================
	// Two flops before use, then edge compare on the stable copy
	// ==========================================================
	always_comb
	begin
		s_d = s_q;
		s_d.meta = ext_pin;
		s_d.stable = s_q.meta;
		s_d.last = s_q.stable;
		// No edge until a real pin sample has reached the last stage
		s_d.filled = {s_q.filled[1:0], 1'b1};
		if (edge_rising)
		begin
			edge_pulse = s_q.filled[2] & s_q.stable & ~s_q.last;
		end
		else
		begin
			edge_pulse = s_q.filled[2] & ~s_q.stable & s_q.last;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule // ext_pin_edge

// *** rtl/irq_source_merge.sv ***
// Combines flags and enables into the request toward the processor
`timescale 1ns/100ps
module irq_source_merge (
	// Flag views
	input wire logic [7:0] flags_0,
	input wire logic [7:0] flags_1,
	input wire logic [7:0] flags_2,
	// Enables
	input wire logic [7:0] enables_0,
	input wire logic [7:0] enables_1,
	input wire logic [7:0] enables_2,
	input wire logic global_irq_enable,
	input wire logic peripheral_group_enable,
	// Request
	output logic want_vector
);

	logic direct_hit;
	logic group_hit;

	always_comb
	begin
		direct_hit = |(flags_0 & enables_0);
		group_hit = peripheral_group_enable
			& |((flags_1 & enables_1) | (flags_2 & enables_2));
		want_vector = global_irq_enable & (direct_hit | group_hit);
	end

endmodule // irq_source_merge

// *** bench/peripheral_irq_flag_bank_props.sv ***
// Checker of bus timing and request gating
`timescale 1ns/100ps
module flag_bank_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Source and request
	input wire logic timer0_overflow,
	input wire logic irq_request
);
	logic glob_q;
	logic t0en_q;
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	// Shadows of the global and timer0 enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			glob_q <= 1'b0;
			t0en_q <= 1'b0;
		end
		else if (wr_done && paddr == 16'h002C)
			glob_q <= pwdata[7];
		else if (wr_done && paddr == 16'h1C58)
			t0en_q <= pwdata[5];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_wait_state: assert property (p_wait_state)
		else $error("no answer after wait state");
	property p_wait_state;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_misaligned: assert property (p_misaligned)
		else $error("misaligned access not refused");
	property p_misaligned;
		psel && penable && !pready && paddr[1:0] != 2'h0 |=> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_unmapped;
		psel && !penable && paddr == 16'h0000 |-> ##2 pready && pslverr;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("bus outputs busy while idle");
	property p_quiet;
		!pready |-> prdata == 32'h0000_0000 && !pslverr;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data upper bits set");
	property p_upper_zero;
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_irq_global: assert property (p_irq_global)
		else $error("request without global enable");
	property p_irq_global;
		!glob_q && !$past(glob_q) |-> !irq_request;
	endproperty
	a_t0_request: assert property (p_t0_request)
		else $error("timer0 request missing");
	property p_t0_request;
		timer0_overflow && glob_q && t0en_q |-> ##2 irq_request;
	endproperty
endmodule // flag_bank_props

bind peripheral_irq_flag_bank flag_bank_props i_flag_bank_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer0_overflow(timer0_overflow), .irq_request(irq_request));

// *** bench/peripheral_model.sv ***
// Behavioural model of the neighbouring peripherals
`timescale 1ns/100ps
module peripheral_model (
	// Clock
	input wire logic pclk,
	// Set events
	output logic [9:0] events,
	// Live levels
	output logic [7:0] pin_flags,
	output logic rx_not_empty,
	output logic tx_empty,
	output logic ext_pin
);
	initial
	begin
		events = 10'h000;
		pin_flags = 8'h00;
		rx_not_empty = 1'b0;
		tx_empty = 1'b0;
		ext_pin = 1'b0;
	end
	// One-cycle pulse, then one quiet cycle
	task fire(input int i);
		events <= 10'h001 << i;
		@(posedge pclk);
		events <= 10'h000;
		@(posedge pclk);
	endtask
	// Per-pin flags held until the next set_pins call
	task set_pins(input logic [7:0] v);
		pin_flags <= v;
	endtask
	// Buffer occupancy levels
	task set_serial(input logic rx, input logic tx);
		rx_not_empty <= rx;
		tx_empty <= tx;
	endtask
	task set_pin(input logic v);
		ext_pin <= v;
	endtask
endmodule // peripheral_model

// *** bench/peripheral_irq_flag_bank_tb.sv ***
// Self-checking bench for the flag bank
`timescale 1ns/100ps
`include "irq_flag_defs.svh"
module peripheral_irq_flag_bank_tb;
	localparam logic [15:0] CTL = {`IDX_IRQ_CONTROL, 2'b00};
	localparam logic [15:0] F0 = {`IDX_REQUEST_FLAGS_0, 2'b00};
	localparam logic [15:0] F1 = {`IDX_REQUEST_FLAGS_1, 2'b00};
	localparam logic [15:0] F2 = {`IDX_REQUEST_FLAGS_2, 2'b00};
	localparam logic [15:0] E0 = {`IDX_SOURCE_ENABLES_0, 2'b00};
	localparam logic [15:0] E1 = {`IDX_SOURCE_ENABLES_1, 2'b00};
	localparam logic [15:0] E2 = {`IDX_SOURCE_ENABLES_2, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, seed, noise;
	logic [9:0] ev;
	logic [7:0] pf;
	logic rxn, txe, pin;
	logic [32:0] exp_q[$];
	int err_count, comparisons, cycles, b;

	always #5 pclk = ~pclk;

	peripheral_irq_flag_bank i_peripheral_irq_flag_bank (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer0_overflow(ev[0]),
		.timer1_event(ev[1]), .timer2_event(ev[2]), .timer1_gate_inactive(ev[3]),
		.capcmp1_event(ev[4]), .capcmp2_event(ev[5]), .sync_serial_event(ev[6]),
		.bus_collision_event(ev[7]), .adc_done_event(ev[8]), .flash_done_event(ev[9]),
		.per_pin_change_flags(pf), .serial_rx_not_empty(rxn), .serial_tx_buffer_empty(txe),
		.ext_pin(pin), .irq_request(irq_request));
	peripheral_model i_peripheral_model (.pclk(pclk), .events(ev), .pin_flags(pf),
		.rx_not_empty(rxn), .tx_empty(txe), .ext_pin(pin));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task end_of_test;
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [32:0] x, input logic [32:0] y);
		comparisons++;
		if (x !== y)
		begin
			err_count++;
			$display("[ERR] %0t exp %h got %h", $time, x, y);
		end
	endtask
	// One APB transfer; the answer is noted first
	task apb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [32:0] x);
		@(posedge pclk);
		exp_q.push_back(x);
		noise = xs(noise);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {noise[31:8], d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00, {25'h000_0000, x});
	endtask
	task irq_is(input logic x);
		repeat (2) @(posedge pclk);
		chk({32'h0000_0000, x}, {32'h0000_0000, irq_request});
	endtask
	// Watcher: oldest note against each answer
	always @(posedge pclk)
	begin
		if (pready === 1'b1)
			chk(exp_q.pop_front(), {pslverr, prdata});
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_count++;
			end_of_test;
		end
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		seed = 32'h0000_6EF0;
		noise = 32'h0000_6EF0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(CTL, 8'h01);
		rd(E2, 8'h00);
		apb(1'b0, 16'h0000, 8'h00, 33'h1_0000_0000);
		apb(1'b1, F0 + 16'h0001, 8'hFF, 33'h1_0000_0000);
		rd(F0, 8'h00);
		for (b = 0; b < 10; b++)
			i_peripheral_model.fire(b);
		rd(F0, 8'h20);
		rd(F1, 8'hE7);
		rd(F2, 8'hE0);
		irq_is(1'b0);
		// Event in the cycle of a clearing write
		fork
			wr(F1, 8'h00);
			begin
				repeat (3) @(posedge pclk);
				i_peripheral_model.fire(2);
			end
		join
		rd(F1, 8'h40);
		wr(F1, 8'h00);
		wr(F2, 8'h00);
		wr(F0, 8'h01);
		rd(F0, 8'h01);
		wr(F0, 8'h00);
		rd(F0, 8'h00);
		rd(F1, 8'h00);
		rd(F2, 8'h00);
		seed = xs(seed);
		i_peripheral_model.set_pins(seed[7:0] | 8'h01);
		wr(F0, 8'h00);
		rd(F0, 8'h10);
		i_peripheral_model.set_pins(8'h00);
		rd(F0, 8'h00);
		i_peripheral_model.set_serial(1'b1, 1'b1);
		rd(F1, 8'h18);
		i_peripheral_model.set_serial(1'b0, 1'b0);
		wr(F1, 8'h18);
		rd(F1, 8'h00);
		// Pin edges under both edge choices
		i_peripheral_model.set_pin(1'b1);
		repeat (6) @(posedge pclk);
		rd(F0, 8'h01);
		wr(F0, 8'h00);
		wr(CTL, 8'h00);
		i_peripheral_model.set_pin(1'b0);
		repeat (6) @(posedge pclk);
		rd(F0, 8'h01);
		wr(F0, 8'h00);
		i_peripheral_model.set_pin(1'b1);
		repeat (6) @(posedge pclk);
		rd(F0, 8'h00);
		wr(E2, 8'hFF);
		rd(E2, 8'hE0);
		wr(E0, 8'hFF);
		rd(E0, 8'h31);
		repeat (3)
		begin
			seed = xs(seed);
			wr(E1, seed[7:0]);
			rd(E1, seed[7:0]);
		end
		wr(CTL, 8'h81);
		i_peripheral_model.fire(0);
		irq_is(1'b1);
		wr(F0, 8'h00);
		irq_is(1'b0);
		wr(CTL, 8'hC1);
		for (b = 5; b < 8; b++)
		begin
			wr(F2, 8'h01 << b);
			wr(E2, 8'h01 << b);
			irq_is(1'b1);
			wr(E2, (8'h01 << b) ^ 8'hE0);
			irq_is(1'b0);
			wr(F2, 8'h00);
		end
		wr(F2, 8'hE0);
		wr(CTL, 8'h81);
		irq_is(1'b0);
		wr(CTL, 8'h41);
		irq_is(1'b0);
		// Reset in mid-run with the pin resting high
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(F0, 8'h00);
		rd(CTL, 8'h01);
		rd(E1, 8'h00);
		repeat (2) @(posedge pclk);
		end_of_test;
	end
endmodule // peripheral_irq_flag_bank_tb
